/* File: core/fpx_classify.sv */
// Combinational classifier of one floating-point operand.
// Assumes the operand and precision select are stable in the cycle they are read.
`timescale 1ns/1ps
`default_nettype none
module fpx_classify
(
   input wire logic [fpx_pkg::OPND_W-1:0] opnd, // Operand word.
   input wire logic dbl, // High for double precision.
   output fpx_pkg::fpx_class_t cls // Class of the operand.
);
   import fpx_pkg::*;
   logic [DP_EXP_W-1:0] efield; // Exponent field, zero extended.
   logic [DP_FRAC_W-1:0] ffield; // Fraction, left aligned.
   logic emax_hit; // Exponent field is all ones.
   logic frac_nz; // Fraction is not zero.
   logic signed [EXP_W-1:0] bias; // Bias of the precision.
   // ****************************************************************
   // Field extraction and classification.
   // ****************************************************************
   // Splits the operand by precision and derives every class flag.
   always_comb
   begin
      cls = '0;
      if (dbl)
      begin
         // Double precision fields.
         efield = opnd[DP_EXP_LSB +: DP_EXP_W];
         ffield = opnd[DP_FRAC_W-1:0];
         cls.sign = opnd[DP_SIGN_POS];
         emax_hit = &opnd[DP_EXP_LSB +: DP_EXP_W];
         bias = DP_BIAS;
      end
      else
      begin
         // Single precision fields in the low word.
         efield = {3'h0, opnd[SP_EXP_LSB +: SP_EXP_W]};
         ffield = {opnd[SP_FRAC_W-1:0], 29'h0};
         cls.sign = opnd[SP_SIGN_POS];
         emax_hit = &opnd[SP_EXP_LSB +: SP_EXP_W];
         bias = SP_BIAS;
      end
      frac_nz = |ffield;
      cls.exp = $signed({2'h0, efield}) - bias;
      cls.frac = ffield;
      cls.is_inf = emax_hit & ~frac_nz;
      cls.is_nan = emax_hit & frac_nz;
      // signalling when top fraction bit clear.
      cls.is_snan = emax_hit & frac_nz & ~ffield[DP_FRAC_W-1];
      // quiet when top fraction bit set.
      cls.is_qnan = emax_hit & frac_nz & ffield[DP_FRAC_W-1];
      cls.is_zero = (efield == 11'h000) & ~frac_nz;
      cls.is_sub = (efield == 11'h000) & frac_nz;
   end
endmodule // fpx_classify
`default_nettype wire

/* File: core/fpx_pe_predict.sv */
// Predicts overflow, underflow and invalid outcomes from exponents, signs and zero and infinity flags.
// Assumes operands are numbers or infinities; NaN cases are resolved by the caller.
`timescale 1ns/1ps
`default_nettype none
module fpx_pe_predict
(
   input wire fpx_pkg::fpx_op_t op, // Operation.
   input wire logic dbl, // High for double precision.
   input wire fpx_pkg::fpx_class_t cn, // First source class.
   input wire fpx_pkg::fpx_class_t cm, // Second source class.
   input wire fpx_pkg::fpx_class_t cd, // Accumulate class.
   output fpx_pkg::fpx_pe_t pe // Predicted outcome flags.
);
   import fpx_pkg::*;
   logic signed [EXP_W:0] en; // Widened first exponent.
   logic signed [EXP_W:0] em; // Widened second exponent.
   logic signed [EXP_W:0] ed; // Widened accumulate exponent.
   logic signed [EXP_W:0] emax; // Largest finite exponent.
   logic signed [EXP_W:0] emin; // Smallest normal exponent.
   logic signed [EXP_W:0] prec; // Cancellation margin.
   logic signed [EXP_W:0] mx; // Larger addend exponent.
   logic eff_sub; // Addition is an effective subtraction.
   // ****************************************************************
   // Prediction.
   // ****************************************************************
   // Conservative bounds: a flag set here only means the result might be exceptional.
   always_comb
   begin
      pe = '0;
      en = {cn.exp[EXP_W-1], cn.exp};
      em = {cm.exp[EXP_W-1], cm.exp};
      ed = {cd.exp[EXP_W-1], cd.exp};
      emax = dbl ? {DP_BIAS[EXP_W-1], DP_BIAS} : {SP_BIAS[EXP_W-1], SP_BIAS};
      emin = dbl ? {DP_EMIN[EXP_W-1], DP_EMIN} : {SP_EMIN[EXP_W-1], SP_EMIN};
      prec = dbl ? {DP_PREC[EXP_W-1], DP_PREC} : {SP_PREC[EXP_W-1], SP_PREC};
      mx = (en > em) ? en : em;
      eff_sub = cn.sign ^ cm.sign ^ (op == FPX_OP_SUB);
      case (op)
         FPX_OP_ADD, FPX_OP_SUB:
         begin
            // Sum may carry out, cancel down, or be an infinity difference.
            pe.ovf = mx >= emax;
            pe.unf = eff_sub & (mx < emin + prec);
            pe.inv = eff_sub & cn.is_inf & cm.is_inf;
         end
         FPX_OP_MUL:
         begin
            // Product exponent is near the sum of exponents.
            pe.ovf = (en + em) >= emax;
            pe.unf = (en + em) <= emin;
            pe.inv = (cn.is_inf & cm.is_zero) | (cn.is_zero & cm.is_inf);
         end
         FPX_OP_DIV:
         begin
            // Quotient exponent is near the difference of exponents.
            pe.ovf = (en - em) >= emax;
            pe.unf = (en - em) <= emin;
            pe.inv = (cn.is_inf & cm.is_inf) | (cn.is_zero & cm.is_zero);
         end
         FPX_OP_MAC:
         begin
            // Product bounds, then the accumulate as an addend.
            pe.ovf = ((en + em) >= emax) | (ed >= emax);
            pe.unf = ((en + em) <= emin) | ((cd.sign ^ cn.sign ^ cm.sign) & (ed < emin + prec));
            pe.inv = (cn.is_inf & cm.is_zero) | (cn.is_zero & cm.is_inf) |
                     ((cn.is_inf | cm.is_inf) & cd.is_inf & (cd.sign ^ cn.sign ^ cm.sign));
         end
         FPX_OP_SQRT:
         begin
            // Root of a negative nonzero value.
            pe.inv = cm.sign & ~cm.is_zero;
         end
         default:
         begin
            // Compares and copies cannot overflow or underflow.
            pe = '0;
         end
      endcase
   end
endmodule // fpx_pe_predict
`default_nettype wire

/* File: core/fpx_pkg.sv */
// Shared constants, enumerations and carrier structs of the special value detector.
// Assumes single precision sits in the low 32 bits of a 64-bit operand word.
`default_nettype none
package fpx_pkg;
   // ****************************************************************
   // Operand formats.
   // ****************************************************************
   localparam int OPND_W = 64;
   localparam int SP_SIGN_POS = 31;
   localparam int SP_EXP_LSB = 23;
   localparam int SP_EXP_W = 8;
   localparam int SP_FRAC_W = 23;
   localparam int DP_SIGN_POS = 63;
   localparam int DP_EXP_LSB = 52;
   localparam int DP_EXP_W = 11;
   localparam int DP_FRAC_W = 52;
   // Signed exponent width used for unbiased exponents and sums.
   localparam int EXP_W = 13;
   localparam logic signed [EXP_W-1:0] SP_BIAS = 13'sh007F;
   localparam logic signed [EXP_W-1:0] DP_BIAS = 13'sh03FF;
   localparam logic signed [EXP_W-1:0] SP_EMIN = -13'sh007E;
   localparam logic signed [EXP_W-1:0] DP_EMIN = -13'sh03FE;
   // Precision in significand bits, used as a cancellation margin.
   localparam logic signed [EXP_W-1:0] SP_PREC = 13'sh0018;
   localparam logic signed [EXP_W-1:0] DP_PREC = 13'sh0035;
   // Intermediate result: wider exponent and fraction plus guard bits.
   localparam int IGRD_W = 3;
   localparam int IFRAC_W = DP_FRAC_W + 1 + IGRD_W;
   // ****************************************************************
   // Enumerations.
   // ****************************************************************
   typedef enum logic [2:0] {
      FPX_OP_ADD = 3'h0, FPX_OP_SUB = 3'h1, FPX_OP_MUL = 3'h2, FPX_OP_DIV = 3'h3,
      FPX_OP_MAC = 3'h4, FPX_OP_SQRT = 3'h5, FPX_OP_CMP = 3'h6, FPX_OP_MOV = 3'h7
   } fpx_op_t;
   typedef enum logic [1:0] {
      FPX_ST_IDLE = 2'h0, FPX_ST_EXC = 2'h1, FPX_ST_BNC = 2'h3
   } fpx_state_t;
   // ****************************************************************
   // Carrier structs.
   // ****************************************************************
   typedef struct packed {
      logic sign;
      logic signed [EXP_W-1:0] exp;
      logic [DP_FRAC_W-1:0] frac;
      logic is_zero;
      logic is_sub;
      logic is_inf;
      logic is_nan;
      logic is_snan;
      logic is_qnan;
   } fpx_class_t;
   typedef struct packed {
      fpx_op_t op;
      logic dbl;
      logic trig;
      logic [OPND_W-1:0] opn;
      logic [OPND_W-1:0] opm;
      logic [OPND_W-1:0] opd;
   } fpx_req_t;
   typedef struct packed {
      logic sign;
      logic signed [EXP_W-1:0] exp;
      logic [IFRAC_W-1:0] frac;
   } fpx_inter_t;
   typedef struct packed {
      logic ovf;
      logic unf;
      logic inv;
   } fpx_pe_t;
   typedef struct packed {
      logic done;
      logic bounce;
      logic in_exc;
      logic trig_bnc;
      logic invalid;
      logic pe;
      logic nan_prop;
      fpx_inter_t result;
   } fpx_rsp_t;
endpackage
`default_nettype wire

/* File: core/fpx_special_detect.sv */
// Special value and exception pre-detection stage of the floating-point coprocessor.
// Assumes the host decodes trigger instructions and drives requests from logic on clock.
`timescale 1ns/1ps
`default_nettype none
module fpx_special_detect
(
   input wire logic clock, // Coprocessor clock, 250 MHz.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; all state holds while low.
   input wire logic req_valid, // Host offers an instruction.
   output logic req_ready, // Instruction can be taken this cycle.
   input wire fpx_pkg::fpx_req_t req, // Instruction and operands.
   output logic rsp_valid, // Answer is offered.
   input wire logic rsp_ready, // Host takes the answer.
   output fpx_pkg::fpx_rsp_t rsp, // Answer flags and intermediate result.
   output logic exc_state // Exceptional state is set.
);
   import fpx_pkg::*;

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   localparam int NOPS = 3; // Source operands n, m and d.

   logic take; // An instruction is accepted.
   logic give; // The answer is handed over.

   logic [OPND_W-1:0] opv [NOPS]; // Operand words by slot.
   fpx_class_t cls [NOPS]; // Operand classes by slot.
   logic [NOPS-1:0] used; // Slots the operation reads.
   logic [NOPS-1:0] sub_v; // Per slot subnormal flags.
   logic [NOPS-1:0] snan_v; // Per slot signalling NaN flags.
   logic [NOPS-1:0] qnan_v; // Per slot quiet NaN flags.

   logic unsupported; // A read operand is unsupported.
   logic snan_any; // A read operand is a signalling NaN.
   logic qnan_any; // A read operand is a quiet NaN.

   fpx_pe_t pe; // Predicted outcome flags.
   logic pe_hit; // Instruction is potentially exceptional.

   fpx_class_t nan_src; // Chosen NaN to propagate.
   fpx_inter_t nan_res; // NaN in intermediate form.

   fpx_rsp_t nxt_rsp; // Answer for the taken instruction.
   fpx_rsp_t rsp_ff; // Registered answer.
   logic rsp_valid_ff; // Registered answer valid.

   fpx_state_t state_ff; // Exceptional state machine.
   fpx_state_t nxt_state; // Next state.

   // ****************************************************************
   // Handshakes.
   // ****************************************************************
   // A new instruction is taken when no answer waits or the waiting one leaves now.
   assign req_ready = ce & (~rsp_valid_ff | rsp_ready);
   assign take = req_valid & req_ready;
   assign give = ce & rsp_valid_ff & rsp_ready;

   assign rsp_valid = rsp_valid_ff;
   assign rsp = rsp_ff;

   // It is high unless idle.
   assign exc_state = (state_ff != FPX_ST_IDLE);

   // ****************************************************************
   // Operand classification.
   // ****************************************************************
   // Slots: n, m, then d.
   assign opv[0] = req.opn;
   assign opv[1] = req.opm;
   assign opv[2] = req.opd;

   // One classifier per operand slot, with its flags gathered into vectors.
   genvar gi;
   generate
      for (gi = 0; gi < NOPS; gi++)
      begin : g_cls
         fpx_classify u_cls
         (
            .opnd (opv[gi]),
            .dbl (req.dbl),
            .cls (cls[gi])
         );

         // Gathered for reductions.
         assign sub_v[gi] = cls[gi].is_sub;
         assign snan_v[gi] = cls[gi].is_snan;
         assign qnan_v[gi] = cls[gi].is_qnan;
      end
   endgenerate

   // Selects which slots each operation reads; copies read no slot, so nothing is inspected.
   always_comb
   begin
      case (req.op)
         FPX_OP_MAC:
         begin
            // Multiply-accumulate reads all three.
            used = 3'h7;
         end
         FPX_OP_SQRT:
         begin
            // Square root reads m only.
            used = 3'h2;
         end
         FPX_OP_MOV:
         begin
            // Copies pass bits unchanged; only a trigger bounce in the exceptional state can trap them.
            used = 3'h0;
         end
         default:
         begin
            // Dyadic operations read n and m.
            used = 3'h3;
         end
      endcase
   end

   // ****************************************************************
   // Exception detection.
   // ****************************************************************
   // subnormals are unsupported operands.
   assign unsupported = |(used & sub_v);

   assign snan_any = |(used & snan_v);

   assign qnan_any = |(used & qnan_v);

   // Prediction from exponents and signs of the read operands.
   fpx_pe_predict u_pred
   (
      .op (req.op),
      .dbl (req.dbl),
      .cn (cls[0]),
      .cm (cls[1]),
      .cd (cls[2]),
      .pe (pe)
   );

   assign pe_hit = (pe.ovf | pe.unf | pe.inv) & ~unsupported & ~snan_any & ~qnan_any;

   // Picks the NaN to propagate: signalling before quiet, then n, m, d in order.
   always_comb
   begin
      nan_src = '0;

      // Quiet candidates first.
      for (int i = NOPS - 1; i >= 0; i--)
      begin
         if (used[i] && qnan_v[i])
         begin
            nan_src = cls[i];
         end
      end

      // Signalling ones win.
      for (int j = NOPS - 1; j >= 0; j--)
      begin
         if (used[j] && snan_v[j])
         begin
            nan_src = cls[j];
         end
      end
   end

   // copy exponent, widen fraction, quieting the NaN.
   always_comb
   begin
      nan_res.sign = nan_src.sign;
      nan_res.exp = nan_src.exp;
      nan_res.frac = {1'h0, 1'h1, nan_src.frac[DP_FRAC_W-2:0], {IGRD_W{1'b0}}};
   end

   // ****************************************************************
   // Answer and next state.
   // ****************************************************************
   // Builds the answer for the taken instruction in priority order.
   always_comb
   begin
      nxt_rsp = '0;
      nxt_state = state_ff;

      if (take)
      begin
         if (state_ff == FPX_ST_EXC && req.trig)
         begin
            nxt_rsp.bounce = 1'b1;
            nxt_rsp.trig_bnc = 1'b1;
            nxt_state = FPX_ST_BNC;
         end
         else if (unsupported)
         begin
            // input exception, handed to support code.
            nxt_rsp.bounce = 1'b1;
            nxt_rsp.in_exc = 1'b1;
         end
         else if (snan_any)
         begin
            nxt_rsp.done = 1'b1;
            nxt_rsp.invalid = 1'b1;
            nxt_rsp.nan_prop = 1'b1;
            nxt_rsp.result = nan_res;
         end
         else if (qnan_any)
         begin
            // quiet NaN passes to the result.
            nxt_rsp.done = 1'b1;
            nxt_rsp.nan_prop = 1'b1;
            nxt_rsp.result = nan_res;
         end
         else
         begin
            // Normal completion; arithmetic result comes from the datapath.
            nxt_rsp.done = 1'b1;
            nxt_rsp.pe = pe_hit;
            if (pe_hit && state_ff == FPX_ST_IDLE)
            begin
               nxt_state = FPX_ST_EXC;
            end
         end
      end
      else if (give && state_ff == FPX_ST_BNC)
      begin
         // clear once the bounce is taken.
         nxt_state = FPX_ST_IDLE;
      end
   end

   // ****************************************************************
   // State registers.
   // ****************************************************************
   // Exceptional state; a new instruction cannot be taken while a bounce waits unseen.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         // Idle after reset.
         state_ff <= FPX_ST_IDLE;
      end
      else if (ce)
      begin
         // held until the bounce is delivered.
         if (take && state_ff == FPX_ST_BNC)
         begin
            // The bounce left in this same cycle; judge the new one from idle.
            state_ff <= (nxt_rsp.pe) ? FPX_ST_EXC : FPX_ST_IDLE;
         end
         else
         begin
            // Ordinary step.
            state_ff <= nxt_state;
         end
      end
   end

   // Answer register; it stands until the host takes it.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         // Nothing waits after reset.
         rsp_valid_ff <= 1'b0;
         rsp_ff <= '0;
      end
      else if (ce)
      begin
         if (take)
         begin
            // host must act on the bounce flag.
            rsp_valid_ff <= 1'b1;
            rsp_ff <= nxt_rsp;
         end
         else if (give)
         begin
            // Answer handed over and nothing new arrived.
            rsp_valid_ff <= 1'b0;
         end
      end
   end
endmodule // fpx_special_detect
`default_nettype wire

/* File: tb/fpx_host_model.sv */
// Host core model that takes answers and runs support code on bounces.
// Assumes answers are offered on rsp_valid and taken at rising edges.
`timescale 1ns/1ps
`default_nettype none
module fpx_host_model
(
   input wire logic clock, // Coprocessor clock.
   input wire logic rstn, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic stall, // High lets the host stall at random.
   input wire logic rsp_valid, // Answer offered.
   input wire logic bounce, // Answer is a bounce.
   output logic rsp_ready, // Host takes the answer.
   output logic [7:0] support_cnt // Support code entries.
);
   initial rsp_ready = 1'b0;
   // Ready changes only at falling edges, random while stalling.
   always @(negedge clock) rsp_ready <= !stall || ($urandom % 2 == 0);
   always @(posedge clock or negedge rstn)
      if (!rstn) support_cnt <= 8'h00;
      else if (ce && rsp_valid && rsp_ready && bounce) support_cnt <= support_cnt + 8'h01;
endmodule // fpx_host_model
`default_nettype wire

/* File: tb/fpx_special_detect_monitor.sv */
// Concurrent checks on the ports of the special value detector.
// Assumes one clock domain with the asynchronous active low reset rstn.
`timescale 1ns/1ps
`default_nettype none
module fpx_special_detect_monitor
(
   input wire logic clock, // Coprocessor clock.
   input wire logic rstn, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic req_valid, // Request offered.
   input wire logic req_ready, // Request can be taken.
   input wire fpx_pkg::fpx_req_t req, // Request carrier.
   input wire logic rsp_valid, // Answer offered.
   input wire logic rsp_ready, // Answer taken.
   input wire fpx_pkg::fpx_rsp_t rsp, // Answer carrier.
   input wire logic exc_state // Exceptional state.
);
   import fpx_pkg::*;
   // ****************************************
   // Helper logic.
   // ****************************************
   // Tests a single word for a NaN of the given quietness.
   function automatic logic nan_sp(input logic [63:0] x, input logic q);
      return x[30:23] == 8'hFF && x[22:0] != 23'h0 && x[22] == q;
   endfunction
   logic tk; // A request is taken at this edge.
   logic add1; // Taken single add, no trigger, second source one.
   logic bnc_out; // A trigger bounce answer leaves at this edge.
   assign tk = ce && req_valid && req_ready;
   assign add1 = tk && req.op == FPX_OP_ADD && !req.dbl && !req.trig && req.opm[31:0] == 32'h3F800000;
   assign bnc_out = rsp_valid && rsp.trig_bnc && ce && rsp_ready;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ****************************************
   // Properties.
   // ****************************************
   // A take while idle, at the edge it is taken.
   sequence s_idle_take;
      tk && !exc_state;
   endsequence
   property p_ready; !ce || (rsp_valid && !rsp_ready) |-> !req_ready; endproperty
   property p_lat; tk |=> rsp_valid; endproperty
   property p_hold; rsp_valid && !(ce && rsp_ready) |=> rsp_valid && $stable(rsp); endproperty
   property p_inf; add1 && req.opn[30:0] == 31'h7F800000 |=> rsp.done && !rsp.nan_prop && rsp.pe; endproperty
   property p_snan; add1 && nan_sp(req.opn, 1'b0) |=> rsp.done && rsp.invalid && rsp.nan_prop; endproperty
   property p_qnan; add1 && nan_sp(req.opn, 1'b1) |=> rsp.nan_prop && !rsp.invalid && !rsp.bounce; endproperty
   property p_sub; add1 && req.opn[30:23] == 8'h00 && req.opn[22:0] != 23'h0 |=> rsp.bounce && rsp.in_exc; endproperty
   property p_enter; s_idle_take ##1 rsp.pe |-> exc_state; endproperty
   property p_bnc; tk && exc_state && req.trig && !(rsp_valid && rsp.trig_bnc) |=> rsp.bounce && rsp.trig_bnc;
   endproperty
   property p_stay; exc_state && !bnc_out |=> exc_state; endproperty
   property p_clear; bnc_out && !tk |=> !exc_state; endproperty
   a_ready: assert property (p_ready) else $error("Request ready while refused.");
   a_lat: assert property (p_lat) else $error("Answer late.");
   a_hold: assert property (p_hold) else $error("Answer changed while waiting.");
   a_inf: assert property (p_inf) else $error("Infinity misread.");
   a_snan: assert property (p_snan) else $error("Signalling source not invalid.");
   a_qnan: assert property (p_qnan) else $error("Quiet source raised a flag.");
   a_sub: assert property (p_sub) else $error("Unsupported source not bounced.");
   a_enter: assert property (p_enter) else $error("Exceptional state not entered.");
   a_bnc: assert property (p_bnc) else $error("Trigger not bounced.");
   a_stay: assert property (p_stay) else $error("Exceptional state left early.");
   a_clear: assert property (p_clear) else $error("Exceptional state kept.");
endmodule // fpx_special_detect_monitor
bind fpx_special_detect fpx_special_detect_monitor u_mon (.clock, .rstn, .ce, .req_valid, .req_ready, .req,
   .rsp_valid, .rsp_ready, .rsp, .exc_state);
`default_nettype wire

/* File: tb/fpx_testbench.sv */
// Self-checking bench of the special value detector with a host model.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fpx_pkg::*;
   localparam int RW = $bits(fpx_rsp_t);
   localparam logic [63:0] SP1 = 64'h3F800000;
   logic clock = 1'b0; // Coprocessor clock.
   logic rstn = 1'b0; // Reset, active low.
   logic ce = 1'b1; // Clock enable.
   logic req_valid = 1'b0; // Request offered.
   logic req_ready; // Request can be taken.
   fpx_req_t req = '0; // Request carrier.
   logic rsp_valid; // Answer offered.
   logic rsp_ready; // Answer taken.
   fpx_rsp_t rsp; // Answer carrier.
   logic exc_state; // Exceptional state.
   logic stall = 1'b0; // Host stall control.
   logic [7:0] support_cnt; // Bounces seen by the host.
   logic [31:0] r; // Random word.
   int n_mismatch = 0;
   int checks_done = 0;
   int st = 0; // Model state: idle, exceptional, bounce pending.
   logic [7:0] nb = 8'h00; // Bounces expected.
   fpx_rsp_t exp_q[$]; // Expected answers, oldest first.
   always #2 clock = ~clock;
   fpx_special_detect DUT (.clock, .rstn, .ce, .req_valid, .req_ready, .req, .rsp_valid, .rsp_ready, .rsp,
      .exc_state);
   fpx_host_model host (.clock, .rstn, .ce, .stall, .rsp_valid, .bounce(rsp.bounce), .rsp_ready, .support_cnt);
   // Compares one value and counts it.
   task automatic check(input logic [RW-1:0] seen, want);
      checks_done++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic stop_test;
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Returns subnormal, signalling and quiet marks of one source.
   function automatic logic [2:0] kind(input logic [63:0] x, input logic d);
      logic [10:0] e;
      logic [51:0] f;
      e = d ? x[62:52] : {3'h0, x[30:23]};
      f = d ? x[51:0] : {x[22:0], 29'h0};
      if (e == 11'h000) return {f != 52'h0, 2'h0};
      if (e == (d ? 11'h7FF : 11'h0FF) && f != 52'h0) return {1'b0, !f[51], f[51]};
      return 3'h0;
   endfunction
   // Makes a random single NaN of the given quietness.
   function automatic logic [63:0] nan(input logic q);
      logic [31:0] w;
      w = $urandom;
      return {32'h0, w[31], 8'hFF, q, w[21:1], 1'b1};
   endfunction
   // Notes the expected answer, then offers one request until taken.
   task automatic send(input fpx_op_t op, input logic d, t, input logic [63:0] n, m, a, input logic pe);
      fpx_rsp_t w;
      logic [2:0] k [3];
      logic [63:0] v [3];
      logic [2:0] rd;
      logic [51:0] f;
      int sel;
      w = '0;
      sel = -1;
      v = '{n, m, a};
      rd = op == FPX_OP_MAC ? 3'h7 : op == FPX_OP_SQRT ? 3'h2 : op == FPX_OP_MOV ? 3'h0 : 3'h3;
      for (int i = 0; i < 3; i++) k[i] = rd[i] ? kind(v[i], d) : 3'h0;
      if (st == 2) st = 0;
      if (st == 1 && t)
      begin
         w.bounce = 1'b1;
         w.trig_bnc = 1'b1;
         st = 2;
      end
      else if (k[0][2] | k[1][2] | k[2][2])
      begin
         w.bounce = 1'b1;
         w.in_exc = 1'b1;
      end
      else
      begin
         w.done = 1'b1;
         for (int i = 2; i >= 0; i--) if (k[i][0]) sel = i;
         for (int i = 2; i >= 0; i--) if (k[i][1]) sel = i;
         if (sel >= 0)
         begin
            w.nan_prop = 1'b1;
            w.invalid = k[0][1] | k[1][1] | k[2][1];
            w.result.sign = d ? v[sel][63] : v[sel][31];
            w.result.exp = d ? 13'sh0400 : 13'sh0080;
            f = d ? v[sel][51:0] : {v[sel][22:0], 29'h0};
            w.result.frac = {2'h1, f[50:0], 3'h0};
         end
         else
         begin
            w.pe = pe;
            if (pe && st == 0) st = 1;
         end
      end
      if (w.bounce) nb++;
      req = '{op, d, t, n, m, a};
      req_valid = 1'b1;
      #1;
      while (req_ready !== 1'b1)
      begin
         @(negedge clock);
         #1;
      end
      exp_q.push_back(w);
      @(negedge clock);
   endtask
   // Withdraws the request for some cycles.
   task automatic gap(input int c);
      req_valid = 1'b0;
      repeat (c) @(negedge clock);
   endtask
   // Compares each answer as the host takes it.
   always @(posedge clock)
      if (rstn && rsp_valid === 1'b1 && rsp_ready === 1'b1 && ce === 1'b1)
      begin
         if (exp_q.size() == 0) check(1'b1, 1'b0);
         else check(rsp, exp_q.pop_front());
      end
   // Cuts a hung run short.
   initial
   begin
      #40000;
      n_mismatch++;
      stop_test;
   end
   // Main sequence of scenarios.
   initial
   begin
      void'($urandom(32'h3880CDD2));
      repeat (8) @(negedge clock);
      rstn = 1'b1;
      // plain sum, then a sum that may overflow.
      send(FPX_OP_ADD, 0, 0, SP1, SP1, 0, 0);
      send(FPX_OP_ADD, 0, 0, 64'h7F000000, 64'h7F000000, 0, 1);
      send(FPX_OP_ADD, 0, 0, nan(1), SP1, 0, 0);
      send(FPX_OP_MUL, 0, 1, SP1, SP1, 0, 0);
      gap(2);
      send(FPX_OP_MUL, 0, 1, SP1, SP1, 0, 0);
      send(FPX_OP_ADD, 0, 0, nan(0), SP1, 0, 0);
      send(FPX_OP_ADD, 0, 0, 64'h1, SP1, 0, 0);
      send(FPX_OP_ADD, 0, 0, 64'h7F800000, SP1, 0, 1);
      send(FPX_OP_MOV, 0, 0, nan(0), SP1, 0, 0);
      send(FPX_OP_SQRT, 0, 0, nan(0), SP1, 0, 0);
      send(FPX_OP_MAC, 0, 1, SP1, SP1, SP1, 0);
      send(FPX_OP_MAC, 0, 0, SP1, SP1, nan(0), 0);
      // Clock enable low refuses requests.
      ce = 1'b0;
      repeat (3)
      begin
         @(negedge clock);
         check(req_ready, 1'b0);
      end
      ce = 1'b1;
      // double quiet source keeps the wide result.
      r = $urandom;
      send(FPX_OP_ADD, 1, 0, {r[31], 11'h7FF, 1'b1, r[30:0], r[19:0]}, 64'h3FF0000000000000, 0, 0);
      // every operation with a quiet source.
      for (int i = 0; i < 8; i++) send(fpx_op_t'(i), 0, 0, SP1, nan(1), SP1, 0);
      // random NaN sources while the host stalls.
      stall = 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         r = $urandom;
         if (r[0]) send(FPX_OP_ADD, 0, 0, nan(r[1]), SP1, 0, 0);
         else send(FPX_OP_SUB, 0, 0, SP1, nan(r[1]), 0, 0);
      end
      gap(1);
      stall = 1'b0;
      for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge clock);
      check(exp_q.size(), 0);
      check(support_cnt, nb);
      stop_test;
   end
endmodule // testbench
`default_nettype wire
